// ==== core/psram_register_space.sv ====
// register space and transaction sequencer of the ddr psram device side.
// assumes bus_clock, chip select and dq arrive from the host asynchronously
// and are oversampled by sys_clk_in at several samples per bus clock phase.
`timescale 1ns/1ns
`default_nettype none

module psram_register_space
   import psram_register_space_pkg::*;
#(
   parameter logic [3:0] MAKER_CODE = 4'h5,  // arbitrary value
   parameter logic [3:0] TYPE_CODE  = 4'h6   // arbitrary value
) (
   // system
   input  wire logic                   sys_clk_in,
   input  wire logic                   rst_n_in,
   // host bus pins
   input  wire logic                   bus_clock_in,
   input  wire logic                   chip_sel_n_in,
   input  wire logic [7:0]             dq_in,
   output logic      [7:0]             dq_out,
   output logic                        dq_oe_out,
   input  wire logic                   strobe_mask_in,
   output logic                        strobe_mask_out,
   output logic                        strobe_mask_oe_out,
   // array side
   input  wire logic                   refresh_active_in,
   output logic                        array_access_out,
   output logic                        array_write_out,
   output logic [WORD_ADDR_W-1:0]      word_addr_out,
   output logic                        word_step_out,
   // configuration state
   output logic                        normal_power_out,
   output logic [2:0]                  drive_strength_out
);

   // ------------------------------------------------------------------
   // latency decode, used for both one and two count cases
   // ------------------------------------------------------------------
   function automatic logic [4:0] lat_clocks(input logic [3:0] code);
      logic [4:0] n;
      n = 5'h06;                       // reserved codes act as default
      unique case (code)
         LAT_CODE_5: n = 5'h05;
         LAT_CODE_6: n = 5'h06;
         LAT_CODE_8: n = 5'h08;
         LAT_CODE_3: n = 5'h03;
         LAT_CODE_4: n = 5'h04;
         default:    n = 5'h06;
      endcase
      return n;
   endfunction

   // ------------------------------------------------------------------
   // wrap mask in words for the burst length code
   // ------------------------------------------------------------------
   function automatic logic [5:0] wrap_mask(input logic [1:0] code);
      logic [5:0] m;
      m = 6'h0f;
      unique case (code)
         BURST_128: m = 6'h3f;         // 64 words
         BURST_64:  m = 6'h1f;         // 32 words
         BURST_16:  m = 6'h07;         // 8 words
         BURST_32:  m = 6'h0f;         // 16 words
      endcase
      return m;
   endfunction

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic       ck_s1_q, ck_s2_q, ck_s3_q;  // bus clock, s3 for edges
   logic       cs_s1_q, cs_s2_q;           // chip select, active low
   logic [7:0] dq_s1_q, dq_s2_q;           // data bytes

   // two flops per pin, a third on the clock; the second stage is looked at, the third only for clock edges
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
      end else begin
         ck_s1_q <= bus_clock_in;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         cs_s1_q <= chip_sel_n_in;
         cs_s2_q <= cs_s1_q;
         dq_s1_q <= dq_in;
         dq_s2_q <= dq_s1_q;
      end
   end

   // edge finding on the synchronised clock
   wire ck_rise  = ck_s2_q & ~ck_s3_q;
   wire ck_fall  = ~ck_s2_q & ck_s3_q;
   wire ck_edge  = ck_rise | ck_fall;
   wire selected = ~cs_s2_q;

   // ------------------------------------------------------------------
   // transaction state
   // ------------------------------------------------------------------
   xfer_state_t       st_q, st_d;
   logic [CA_WIDTH-1:0] ca_q;          // shifted in msb byte first
   logic [2:0]        edge_cnt_q;      // bus clock edges inside ca
   logic [4:0]        lat_cnt_q;       // rising edges of latency
   logic              extra_lat_q;     // level shown during ca
   logic [15:0]       cfg_q;           // configuration word zero
   logic [7:0]        wr_hi_q;         // first byte of write word
   logic [15:0]       rd_word_q;       // word held for repeat reads
   logic [WORD_ADDR_W-1:0] addr_q;     // array word address
   logic [WORD_ADDR_W-1:0] start_q;    // first word of the burst
   logic [5:0]        wcnt_q;          // words done inside wrap group
   logic              linear_now_q;    // linear stepping: linear burst or hybrid wrap done
   logic              is_reg_rd_q;     // register read under way

   // ------------------------------------------------------------------
   // decode of the captured command_address
   // ------------------------------------------------------------------
   wire [CA_WIDTH-1:0] ca_full = {ca_q[CA_WIDTH-9:0], dq_s2_q};
   wire       is_read   = ca_full[CA_READ_BIT];
   wire       is_reg    = ca_full[CA_SPACE_BIT];
   wire       is_linear = ca_full[CA_LINEAR_BIT];
   wire [7:0] bank_sel  = ca_q[CA_BANK_LSB+7:CA_BANK_LSB];
   wire [7:0] idx_sel   = ca_q[CA_INDEX_LSB+7:CA_INDEX_LSB];
   // group byte then index byte pick the register
   wire sel_id0 = (bank_sel == BANK_IDENT)  && (idx_sel == INDEX_ZERO);
   wire sel_id1 = (bank_sel == BANK_IDENT)  && (idx_sel == INDEX_ONE);
   wire sel_cfg = (bank_sel == BANK_CONFIG) && (idx_sel == INDEX_ZERO);

   // identity words are constants, never storage
   wire [15:0] id0_word = {3'b000, ROW_BITS_CODE,
                           COL_BITS_CODE,
                           MAKER_CODE};
   wire [15:0] id1_word = {12'h000, TYPE_CODE};
   // unmapped registers read as zero
   wire [15:0] reg_rd_word = sel_id0 ? id0_word :
                             sel_id1 ? id1_word :
                             sel_cfg ? cfg_q : 16'h0000;

   // configuration fields
   wire       fixed_lat  = cfg_q[CFG_FIXED_BIT];
   wire       legacy     = cfg_q[CFG_LEGACY_BIT];
   wire [4:0] one_lat    = lat_clocks(cfg_q[CFG_LAT_LSB+3:CFG_LAT_LSB]);
   // fixed latency always shows refresh latency
   wire       show_extra = fixed_lat | refresh_active_in;
   wire [4:0] total_lat  = extra_lat_q ? 5'((one_lat << 1)) : one_lat;
   wire       lat_done   = ck_rise && (lat_cnt_q == total_lat - 5'h01);
   wire       ca_last    = ck_edge && (edge_cnt_q == 3'(CA_EDGES - 1));

   // ------------------------------------------------------------------
   // wrapped burst address step
   // ------------------------------------------------------------------
   wire [5:0] wmask = wrap_mask(cfg_q[CFG_BURST_LSB+1:CFG_BURST_LSB]);
   wire [WORD_ADDR_W-1:0] wmask_w  = {{(WORD_ADDR_W-6){1'b0}}, wmask};
   wire [WORD_ADDR_W-1:0] addr_inc = addr_q + 22'h000001;
   // stay inside the aligned group, wrapping round
   wire [WORD_ADDR_W-1:0] addr_wrap = (addr_q & ~wmask_w) |
                                      (addr_inc & wmask_w);
   // next group begins right after the start's group
   wire [WORD_ADDR_W-1:0] next_group = (start_q | wmask_w) +
                                       22'h000001;
   wire group_end = (wcnt_q == wmask);
   wire [WORD_ADDR_W-1:0] addr_next =
      linear_now_q                   ? addr_inc   :
      (!legacy && group_end)         ? next_group :
                                       addr_wrap;
   wire word_done = ck_fall && (st_q == ST_ADATA);

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE:  if (selected) st_d = ST_CA;
         ST_CA: begin
            if (ca_last) begin
               // register writes go straight to data
               if (is_reg && !is_read) st_d = ST_WREG;
               else                    st_d = ST_LAT;
            end
         end
         ST_LAT:   if (lat_done) st_d = is_reg_rd_q ? ST_RDATA : ST_ADATA;
         ST_WREG:  if (ck_fall)  st_d = ST_DONE;  // one word only
         ST_RDATA: st_d = ST_RDATA;
         ST_ADATA: st_d = ST_ADATA;
         ST_DONE:  st_d = ST_DONE;
         default:  st_d = ST_IDLE;
      endcase
      if (!selected) st_d = ST_IDLE;  // chip select high ends all
   end

   // ------------------------------------------------------------------
   // state, counters and command capture
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         st_q       <= ST_IDLE;
         ca_q       <= '0;
         edge_cnt_q <= 3'h0;
         lat_cnt_q  <= 5'h00;
      end else begin
         st_q <= st_d;
         if (st_q == ST_IDLE) begin
            edge_cnt_q <= 3'h0;
            lat_cnt_q  <= 5'h00;
         end else if (ck_edge && st_q == ST_CA) begin
            ca_q       <= ca_full;
            edge_cnt_q <= ca_last ? 3'h0 : edge_cnt_q + 3'h1;
         end else if (ck_rise && st_q == ST_LAT) begin
            lat_cnt_q  <= lat_cnt_q + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // configuration word and register write
   // ------------------------------------------------------------------
   // writes are taken whenever they arrive; standby is the only time
   // a host can issue one, so no extra gating is kept here
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cfg_q   <= CFG_RESET;
         wr_hi_q <= 8'h00;
      end else if (st_q == ST_WREG) begin
         if (ck_rise) wr_hi_q <= dq_s2_q;
         // whole word stored, mask pin not consulted
         if (ck_fall && sel_cfg) cfg_q <= {wr_hi_q, dq_s2_q};
      end
   end

   // ------------------------------------------------------------------
   // strobe_mask during command_address
   // ------------------------------------------------------------------
   // driven from the first cycle of select, before the command is
   // known, since the host needs it for latency on every transaction but a register write
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         extra_lat_q        <= 1'b1;
         strobe_mask_out    <= 1'b0;
         strobe_mask_oe_out <= 1'b0;
      end else begin
         unique case (st_d)
            ST_CA: begin
               if (st_q == ST_IDLE) extra_lat_q <= show_extra;
               strobe_mask_out    <= (st_q == ST_IDLE) ? show_extra
                                                       : extra_lat_q;
               strobe_mask_oe_out <= 1'b1;
            end
            ST_RDATA: begin
               // read strobe: high with the first byte, low second
               if (ck_rise) strobe_mask_out <= 1'b1;
               if (ck_fall) strobe_mask_out <= 1'b0;
               strobe_mask_oe_out <= (st_q == ST_RDATA) |
                                     strobe_mask_oe_out;
            end
            ST_LAT: begin
               // read preamble: low before the first data edge
               strobe_mask_out    <= 1'b0;
               strobe_mask_oe_out <= (st_q == ST_CA) ? is_reg & is_read
                                                     : is_reg_rd_q;
            end
            default: begin
               strobe_mask_out    <= 1'b0;
               strobe_mask_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // register read data path
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         is_reg_rd_q <= 1'b0;
         rd_word_q   <= 16'h0000;
         dq_out      <= 8'h00;
         dq_oe_out   <= 1'b0;
      end else begin
         if (st_q == ST_CA && ca_last) begin
            is_reg_rd_q <= is_reg & is_read;
         end
         if (st_q == ST_LAT) rd_word_q <= reg_rd_word;
         if (st_d == ST_RDATA && ck_edge) begin
            // the same word repeats while clocked
            dq_out    <= ck_rise ? rd_word_q[15:8] : rd_word_q[7:0];
            dq_oe_out <= 1'b1;
         end else if (st_d != ST_RDATA) begin
            dq_out    <= 8'h00;
            dq_oe_out <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // array burst address sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         addr_q           <= '0;
         start_q          <= '0;
         wcnt_q           <= 6'h00;
         linear_now_q     <= 1'b0;
         array_access_out <= 1'b0;
         array_write_out  <= 1'b0;
         word_step_out    <= 1'b0;
      end else begin
         word_step_out <= word_done;
         if (st_q == ST_CA && ca_last && !is_reg) begin
            addr_q  <= {ca_full[CA_ROWCOL_MSB:CA_ROWCOL_LSB],
                        ca_full[CA_HALF_MSB:0]};
            start_q <= {ca_full[CA_ROWCOL_MSB:CA_ROWCOL_LSB],
                        ca_full[CA_HALF_MSB:0]};
            wcnt_q  <= 6'h00;
            linear_now_q    <= is_linear;
            array_write_out <= ~is_read;
         end else if (word_done) begin
            addr_q <= addr_next;
            wcnt_q <= wcnt_q + 6'h01;
            if (!legacy && group_end) linear_now_q <= 1'b1;
         end
         array_access_out <= (st_d == ST_ADATA);
      end
   end

   // ------------------------------------------------------------------
   // outputs taken from flops
   // ------------------------------------------------------------------
   assign word_addr_out      = addr_q;
   assign normal_power_out   = cfg_q[CFG_POWER_BIT];
   assign drive_strength_out =
      cfg_q[CFG_DRIVE_LSB+2:CFG_DRIVE_LSB];
   // latency and length fields used above

   // strobe_mask input is unused: register writes never mask and
   // array data masking belongs to the array side
   wire unused_mask = strobe_mask_in;

endmodule

`default_nettype wire

// ==== core/psram_register_space_pkg.sv ====
// constants shared by the register space of the ddr pseudo-static dram.
// assumes a single system clock that oversamples the host bus clock.
package psram_register_space_pkg;
   // --------------------------------------------------------------
   // command_address layout
   // --------------------------------------------------------------
   localparam int CA_WIDTH       = 48;   // six bytes, msb first
   localparam int CA_READ_BIT    = 47;   // 1 read, 0 write
   localparam int CA_SPACE_BIT   = 46;   // 1 register space
   localparam int CA_LINEAR_BIT  = 45;   // 1 linear, 0 wrapped
   localparam int CA_BANK_LSB    = 24;   // register group byte
   localparam int CA_INDEX_LSB   = 0;    // register index byte
   localparam int CA_ROWCOL_LSB  = 16;   // word address a21..a3
   localparam int CA_ROWCOL_MSB  = 34;
   localparam int CA_HALF_MSB    = 2;    // word address a2..a0
   localparam int CA_EDGES       = 6;    // bus clock edges of ca
   localparam int WORD_ADDR_W    = 22;

   // --------------------------------------------------------------
   // register addresses
   // --------------------------------------------------------------
   localparam logic [7:0] BANK_IDENT  = 8'h00;
   localparam logic [7:0] BANK_CONFIG = 8'h01;
   localparam logic [7:0] INDEX_ZERO  = 8'h00;
   localparam logic [7:0] INDEX_ONE   = 8'h01;

   // --------------------------------------------------------------
   // identity field values and positions
   // --------------------------------------------------------------
   localparam logic [4:0] ROW_BITS_CODE = 5'h0c;  // thirteen row bits
   localparam logic [3:0] COL_BITS_CODE = 4'h8;   // nine column bits
   localparam int ID0_ROW_LSB = 8;
   localparam int ID0_COL_LSB = 4;

   // --------------------------------------------------------------
   // configuration word fields and reset value
   // --------------------------------------------------------------
   localparam logic [15:0] CFG_RESET   = 16'h8f1f;
   localparam int CFG_POWER_BIT  = 15;
   localparam int CFG_DRIVE_LSB  = 12;
   localparam int CFG_LAT_LSB    = 4;
   localparam int CFG_FIXED_BIT  = 3;
   localparam int CFG_LEGACY_BIT = 2;
   localparam int CFG_BURST_LSB  = 0;

   // initial latency codes
   localparam logic [3:0] LAT_CODE_5 = 4'h0;
   localparam logic [3:0] LAT_CODE_6 = 4'h1;
   localparam logic [3:0] LAT_CODE_8 = 4'h3;
   localparam logic [3:0] LAT_CODE_3 = 4'he;
   localparam logic [3:0] LAT_CODE_4 = 4'hf;

   // wrapped burst length codes
   localparam logic [1:0] BURST_128 = 2'h0;
   localparam logic [1:0] BURST_64  = 2'h1;
   localparam logic [1:0] BURST_16  = 2'h2;
   localparam logic [1:0] BURST_32  = 2'h3;

   // transaction states, gray along idle-ca-latency-register read data
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_CA    = 3'h1,
      ST_LAT   = 3'h3,
      ST_RDATA = 3'h2,
      ST_ADATA = 3'h6,
      ST_WREG  = 3'h7,
      ST_DONE  = 3'h5
   } xfer_state_t;
endpackage

// ==== tb/psram_register_space_assertions.sv ====
// pin checker for the psram register space, bound to the device side.
// assumes one system clock and the synchronous low reset of the block.
`timescale 1ns/1ns
`default_nettype none
module psram_register_space_assertions (
   // watched ports
   input wire logic       sys_clk_in,
   input wire logic       rst_n_in,
   input wire logic       chip_sel_n_in,
   input wire logic       dq_oe_out,
   input wire logic       strobe_mask_out,
   input wire logic       strobe_mask_oe_out,
   input wire logic       refresh_active_in,
   input wire logic       array_access_out,
   input wire logic       normal_power_out,
   input wire logic [2:0] drive_strength_out
);
   // ------------------------------------------------
   // pin relations
   // ------------------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // outputs come out of reset at their defaults
   property p_reset_defaults;
      $rose(rst_n_in) |-> normal_power_out && !drive_strength_out && !dq_oe_out;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("reset defaults wrong");
   property p_mask_idle;
      chip_sel_n_in [*8] |-> !strobe_mask_oe_out && !dq_oe_out;
   endproperty
   a_mask_idle: assert property (p_mask_idle)
      else $error("pins driven while unselected");
   property p_mask_select;
      $fell(chip_sel_n_in) |-> ##[1:6] strobe_mask_oe_out;
   endproperty
   a_mask_select: assert property (p_mask_select)
      else $error("strobe_mask not driven after select");
   property p_release;
      $rose(chip_sel_n_in) |-> ##[1:6] !strobe_mask_oe_out && !dq_oe_out;
   endproperty
   a_release: assert property (p_release)
      else $error("pins held after deselect");
   // refresh shows as a high strobe when the device first drives it
   property p_mask_refresh;
      $rose(strobe_mask_oe_out) && refresh_active_in
         && $past(refresh_active_in) |-> strobe_mask_out;
   endproperty
   a_mask_refresh: assert property (p_mask_refresh)
      else $error("refresh not shown on strobe_mask");
   property p_dq_with_mask;
      dq_oe_out |-> strobe_mask_oe_out;
   endproperty
   a_dq_with_mask: assert property (p_dq_with_mask)
      else $error("read data without strobe");
   // configuration only moves inside a transaction
   property p_cfg_stable;
      chip_sel_n_in [*8] |-> $stable(normal_power_out)
         && $stable(drive_strength_out);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable)
      else $error("configuration moved while idle");
   property p_array_idle;
      chip_sel_n_in [*8] |-> !array_access_out;
   endproperty
   a_array_idle: assert property (p_array_idle)
      else $error("array access while idle");
   c_read_data: cover property ($rose(dq_oe_out));
   c_power_down: cover property ($fell(normal_power_out));
   c_refresh: cover property ($rose(strobe_mask_oe_out) && refresh_active_in);
endmodule
`default_nettype wire

// ==== tb/host_bus_model.sv ====
// host bus master model: clock, select and dq for the psram device side.
// assumes the device splits dq and strobe_mask into value and enable.
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
   // device drive of the shared pins
   input  wire logic [7:0] dev_dq_in,
   input  wire logic       dev_dq_oe_in,
   input  wire logic       dev_mask_in,
   input  wire logic       dev_mask_oe_in,
   // resolved pins seen by the device
   output logic            bus_clock_out,
   output logic            chip_sel_n_out,
   output wire logic [7:0] dq_wire_out,
   output wire logic       mask_wire_out
);
   // ------------------------------------------------
   // pin state and per edge samples
   // ------------------------------------------------
   logic [7:0] host_dq = 8'h00; // byte the host drives
   logic       host_oe = 1'b0;  // host drives dq
   logic [7:0] float_q = 8'h5a; // undriven lines wander, never hold
   logic [7:0] smp_dq [64];     // device outputs after each edge
   logic       smp_ms [64];
   logic       smp_mo [64];
   initial bus_clock_out = 1'b0; // clock stands low outside frames
   initial chip_sel_n_out = 1'b1;
   always #20 float_q = ~float_q;
   assign dq_wire_out = dev_dq_oe_in ? dev_dq_in : host_oe ? host_dq : float_q;
   // host never drives strobe_mask
   assign mask_wire_out = dev_mask_oe_in ? dev_mask_in : float_q[0];
   // ------------------------------------------------
   // one transaction of n bus edges, bytes centred on edges
   // ------------------------------------------------
   task automatic xfer(input logic [47:0] ca, input logic [15:0] wd,
                       input int n);
      logic [63:0] b;
      b = {ca, wd};
      #7 chip_sel_n_out = 1'b0; // select with clock low
      #80;
      for (int e = 0; e < n; e++) begin
         // write word follows ca at once
         host_oe = (e < 6) || (!ca[47] && e < 8);
         host_dq = b[63:56];
         b = b << 8;
         #40 bus_clock_out = ~bus_clock_out;
         #20 smp_dq[e] = dev_dq_in;
         smp_ms[e] = dev_mask_in;
         smp_mo[e] = dev_mask_oe_in;
         #20;
      end
      host_oe = 1'b0;
      #80 chip_sel_n_out = 1'b1; // deselect only with clock idle
      #200;
   endtask
endmodule
`default_nettype wire

// ==== tb/psram_register_space_bench.sv ====
// self-checking bench for the psram register space.
// assumes the host model drives every bus pin of the device.
`timescale 1ns/1ns
`default_nettype none
module psram_register_space_bench;
   import psram_register_space_pkg::*;
   // ------------------------------------------------
   // clock, reset and pins
   // ------------------------------------------------
   logic       sys_clk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic       refresh = 1'b0; // array refresh level
   wire        bclk, csn, msk_in, msk, msk_oe, dq_oe, np;
   wire  [7:0] dq_in, dq;
   wire  [2:0] drv;
   wire [21:0] wa; // array word address
   int         fails = 0;
   int         samples_checked = 0;
   always #10 sys_clk_in = ~sys_clk_in;
   // maker and type codes are arbitrary
   psram_register_space #(.MAKER_CODE(4'h9), .TYPE_CODE(4'ha)) u_dut (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus_clock_in(bclk),
      .chip_sel_n_in(csn), .dq_in(dq_in), .dq_out(dq), .dq_oe_out(dq_oe),
      .strobe_mask_in(msk_in), .strobe_mask_out(msk),
      .strobe_mask_oe_out(msk_oe), .refresh_active_in(refresh),
      .array_access_out(), .array_write_out(), .word_addr_out(wa),
      .word_step_out(), .normal_power_out(np), .drive_strength_out(drv));
   host_bus_model u_host (.dev_dq_in(dq), .dev_dq_oe_in(dq_oe),
      .dev_mask_in(msk), .dev_mask_oe_in(msk_oe), .bus_clock_out(bclk),
      .chip_sel_n_out(csn), .dq_wire_out(dq_in), .mask_wire_out(msk_in));
   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic compare(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] bank, idx, input logic [15:0] d);
      u_host.xfer({8'h60, 8'h00, bank, 16'h0000, idx}, d, 8);
      compare("mask release", 16'h0000, 16'(u_host.smp_mo[7]));
   endtask
   // read with l latency clocks, mask level m in ca, bits k compared
   task automatic rd(input logic [7:0] bank, idx, input int l,
                     input logic m, input logic [15:0] e, k);
      int h;
      h = 5 + 2 * l;
      u_host.xfer({8'hc0, 8'h00, bank, 16'h0000, idx}, 16'h0000, 2 * l + 10);
      compare("ca mask", {14'h0, 1'b1, m},
              {14'h0, u_host.smp_mo[2], u_host.smp_ms[2]});
      compare("strobe", 16'h0005, {11'h0, u_host.smp_ms[h - 2],
              u_host.smp_ms[h - 1], u_host.smp_ms[h], u_host.smp_ms[h + 1],
              u_host.smp_ms[h + 2]});
      compare("word", e & k,
              {u_host.smp_dq[h], u_host.smp_dq[h + 1]} & k);
      compare("repeat", e & k,
              {u_host.smp_dq[h + 2], u_host.smp_dq[h + 3]} & k);
   endtask
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_defaults();
      compare("power drive", 16'h0008, {12'h0, np, drv});
      rd(BANK_CONFIG, INDEX_ZERO, 12, 1'b1, 16'h8f1f, 16'hffff);
   endtask
   task automatic t_identity();
      rd(BANK_IDENT, INDEX_ZERO, 12, 1'b1, 16'h0c89, 16'h1fff);
      rd(BANK_IDENT, INDEX_ONE, 12, 1'b1, 16'h000a, 16'hffff);
      wr(BANK_IDENT, INDEX_ZERO, 16'hf3f6);
      rd(BANK_IDENT, INDEX_ZERO, 12, 1'b1, 16'h0c89, 16'h1fff);
   endtask
   // every latency and drive code, fixed and variable, refresh on and off
   task automatic t_latency();
      logic [3:0] code [8] = '{4'h0, 4'h1, 4'h3, 4'he, 4'hf, 4'h0, 4'h1, 4'h3};
      int n [8] = '{5, 6, 8, 3, 4, 5, 6, 8};
      logic [15:0] c;
      for (int i = 0; i < 8; i++) begin
         c = {1'b1, 3'(i), 4'hf, code[i], i[0], 3'b111};
         @(posedge sys_clk_in) #1 refresh = i[1];
         wr(BANK_CONFIG, INDEX_ZERO, c);
         compare("drive", 16'(i), 16'(drv));
         rd(BANK_CONFIG, INDEX_ZERO, (i[0] | i[1]) ? 2 * n[i] : n[i],
            i[0] | i[1], c, 16'hffff);
      end
      @(posedge sys_clk_in) #1 refresh = 1'b0;
   endtask
   task automatic t_power();
      wr(BANK_CONFIG, INDEX_ZERO, 16'h0f1f);
      compare("power down", 16'h0000, 16'(np));
      wr(BANK_CONFIG, INDEX_ZERO, 16'h8f1f);
      compare("power up", 16'h0001, 16'(np));
   endtask
   // ten-word wrapped array read from word 2 of an 8-word group;
   // the address left after the last word shows the order taken
   task automatic t_wrap();
      wr(BANK_CONFIG, INDEX_ZERO, 16'h8f1a);
      u_host.xfer(48'h8000_0000_0002, 16'h0000, 48);
      compare("hybrid addr", 16'h000a, wa[15:0]);
      wr(BANK_CONFIG, INDEX_ZERO, 16'h8f1e);
      u_host.xfer(48'h8000_0000_0002, 16'h0000, 48);
      compare("legacy addr", 16'h0004, wa[15:0]);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_in);
      #1 rst_n_in = 1'b1;
      repeat (4) @(posedge sys_clk_in);
      t_defaults();
      t_identity();
      t_latency();
      t_power();
      t_wrap();
      end_of_test();
   end
   // a hung transaction ends the run
   initial begin
      #1000000;
      fails++;
      end_of_test();
   end
endmodule
bind psram_register_space psram_register_space_assertions u_chk (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
   .chip_sel_n_in(chip_sel_n_in), .dq_oe_out(dq_oe_out),
   .strobe_mask_out(strobe_mask_out),
   .strobe_mask_oe_out(strobe_mask_oe_out),
   .refresh_active_in(refresh_active_in),
   .array_access_out(array_access_out),
   .normal_power_out(normal_power_out),
   .drive_strength_out(drive_strength_out));
`default_nettype wire
